// *** hw/ibc_pkg.sv ***
// constants and types shared by the instrument bus card glue
package ibc_pkg;
  // host i/o channel decode
  localparam logic [9:0] LOW_PATTERN = 10'h2e1;
  localparam int BASE_LSB = 13;
  localparam int BASE_W = 2;
  localparam int REG_LSB = 10;
  localparam int REG_W = 3;
  localparam int CSEL_BIT = 15;
  localparam logic [15:0] SPECIAL_BASE = 16'h02f0;
  localparam int SPECIAL_LSB = 3;
  localparam logic [2:0] DMA_REG = 3'h0;
  localparam logic [7:0] CLOCK_SPACE_DATA = 8'hff;
  // engine facts and throughput targets
  localparam int ENG_REGS = 21;
  localparam int CLK_HZ = 50_000_000;
  localparam int PIO_RATE_BPS = 20_000;
  localparam int DMA_RATE_BPS = 300_000;
  localparam int CYC_PER_DMA_BYTE = CLK_HZ / DMA_RATE_BPS;
  // apb register offsets
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] CTRL_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  // cfg fields
  localparam int CFG_BASE_LSB = 0;
  localparam int CFG_DMA_LSB = 2;
  localparam int CFG_IRQ_LSB = 4;
  localparam logic [1:0] BASE_RST = 2'h0;
  localparam logic [1:0] DMA_RST = 2'h1;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [2:0] IRQ_MIN = 3'h2;
  // ctrl fields
  localparam int CTRL_IRQEN_BIT = 0;
  localparam int CTRL_DMAEN_BIT = 1;
  // stat fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_FULL_BIT = 3;
  localparam int STAT_POLL_BIT = 4;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WR = 3'b010,
    ST_RD = 3'b100
  } ibc_state_e;

  typedef struct packed {
    logic [2:0] regSel;
    logic [7:0] data;
  } ibc_wr_s;

  typedef struct packed {
    logic [2:0] irqLine;
    logic [1:0] dmaChan;
    logic [1:0] baseSel;
  } ibc_cfg_s;
endpackage

// *** hw/ibc_glue.sv ***
// host channel glue: decode, data routing, irq and dma arbitration
// Functional notes
// - four switch bases, lowest is default
// - low ten lines fixed, top bits base
// - middle bits pick register, one bit chip
// - eight scattered ports reach engine registers
// - claim 02f0-02f7 for interrupt status
// - clock space stays claimed though unfitted
// - decode hit enables engine read/write
// - data buffered on bidirectional internal bus
// - engine irq passes only when enabled
// - track dma enable, detect last transfer
// - dma on channel 1-3 or none
// - irq on line 2-7 or none
// - open collector drivers during parallel poll
// - engine holds twenty-one program registers
// - pio 20k/s, dma 300k/s sustained

////////////////////////////////////////////////////////////////////////
// write buffer fifo
module ibc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = count != (AW + 1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPtr <= '0;
    end else if (push) begin
      wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdPtr <= '0;
    end else if (pop) begin
      rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// top level glue
module ibc_glue #(
  parameter int FIFO_DEPTH = ibc_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // apb configuration port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host i/o channel
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic [7:0] ioDin,
  output logic [7:0] ioDout,
  output logic ioDoe,
  output logic ioRdy,
  output logic [7:0] hostIrq,
  output logic [3:0] hostDrq,
  input wire logic [3:0] hostDack,
  input wire logic hostTc,
  // bus_protocol_engine side
  output logic engCs,
  output logic engRd,
  output logic engWr,
  output logic [2:0] engAddr,
  output logic [7:0] engDout,
  output logic engDoe,
  input wire logic [7:0] engDin,
  input wire logic engRdy,
  input wire logic engIrq,
  input wire logic engDmaReq,
  output logic engDmaAck,
  input wire logic engPollActive,
  output logic clkCs,
  output logic drvOpenCollector
);
  ibc_pkg::ibc_cfg_s cfg;
  ibc_pkg::ibc_state_e state;
  ibc_pkg::ibc_wr_s wrIn;
  ibc_pkg::ibc_wr_s wrOut;
  logic irqEnable;
  logic dmaEnable;
  logic dmaDone;
  logic ackDone;
  logic rdHold;
  logic lowMatch;
  logic baseMatch;
  logic hitEng;
  logic hitClk;
  logic hitSpec;
  logic dmaCycle;
  logic engAccess;
  logic strobe;
  logic wrAck;
  logic fastAck;
  logic fastRead;
  logic engReadStart;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoPop;
  logic apbWrite;
  logic apbRead;
  logic tcSeen;
  logic [7:0] specData;
  logic [2:0] regSel;

  //////////////////////////////////////////////////////////////////////
  // address decode
  assign lowMatch = ioAddr[9:0] == ibc_pkg::LOW_PATTERN;
  assign baseMatch = ioAddr[ibc_pkg::BASE_LSB +: ibc_pkg::BASE_W]
    == cfg.baseSel;
  assign hitEng = lowMatch & baseMatch
    & !ioAddr[ibc_pkg::CSEL_BIT];
  assign hitClk = lowMatch & baseMatch
    & ioAddr[ibc_pkg::CSEL_BIT];
  assign hitSpec = ioAddr[15:ibc_pkg::SPECIAL_LSB]
    == ibc_pkg::SPECIAL_BASE[15:ibc_pkg::SPECIAL_LSB];
  assign dmaCycle = dmaEnable && cfg.dmaChan != 2'h0
    && hostDack[cfg.dmaChan];
  assign engAccess = hitEng | dmaCycle;
  assign regSel = dmaCycle ? ibc_pkg::DMA_REG
    : ioAddr[ibc_pkg::REG_LSB +: ibc_pkg::REG_W];
  assign strobe = (ioRd | ioWr) & !ackDone;
  assign clkCs = hitClk & (ioRd | ioWr);

  //////////////////////////////////////////////////////////////////////
  // host handshake
  assign wrIn.regSel = regSel;
  assign wrIn.data = ioDin;
  assign wrAck = strobe & ioWr & engAccess & fifoInReady;
  assign fastAck = strobe & ioWr & !engAccess & (hitClk | hitSpec);
  assign fastRead = strobe & ioRd & !rdHold & !engAccess
    & (hitClk | hitSpec);
  assign engReadStart = strobe & ioRd & engAccess & !rdHold
    & state == ibc_pkg::ST_IDLE & !fifoOutValid;
  assign ioRdy = wrAck | fastAck | (rdHold & !ackDone);
  assign ioDoe = rdHold;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ackDone <= 1'b0;
    end else if (ioRdy) begin
      ackDone <= 1'b1;
    end else if (!ioRd && !ioWr) begin
      ackDone <= 1'b0;
    end
  end

  assign specData = {3'h0, engPollActive, dmaDone, dmaEnable,
    irqEnable, engIrq};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ioDout <= 8'h00;
      rdHold <= 1'b0;
    end else if (state == ibc_pkg::ST_RD && engRdy) begin
      ioDout <= engDin;
      rdHold <= 1'b1;
    end else if (fastRead) begin
      ioDout <= hitSpec ? specData : ibc_pkg::CLOCK_SPACE_DATA;
      rdHold <= 1'b1;
    end else if (!ioRd) begin
      rdHold <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write buffer, drained by the engine sequencer
  ibc_fifo #(
    .WIDTH($bits(ibc_pkg::ibc_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(wrAck),
    .inReady(fifoInReady),
    .inData(wrIn),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(wrOut)
  );

  assign fifoPop = state == ibc_pkg::ST_IDLE & fifoOutValid;

  //////////////////////////////////////////////////////////////////////
  // engine bus sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ibc_pkg::ST_IDLE;
    end else begin
      case (state)
        ibc_pkg::ST_IDLE: begin
          if (fifoOutValid) begin
            state <= ibc_pkg::ST_WR;
          end else if (engReadStart) begin
            state <= ibc_pkg::ST_RD;
          end
        end
        ibc_pkg::ST_WR, ibc_pkg::ST_RD: begin
          if (engRdy) begin
            state <= ibc_pkg::ST_IDLE;
          end
        end
        default: state <= ibc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      engAddr <= 3'h0;
      engDout <= 8'h00;
    end else if (fifoPop) begin
      engAddr <= wrOut.regSel;
      engDout <= wrOut.data;
    end else if (engReadStart) begin
      engAddr <= regSel;
    end
  end

  assign engWr = state == ibc_pkg::ST_WR;
  assign engRd = state == ibc_pkg::ST_RD;
  assign engDoe = engWr;
  assign engCs = engWr | engRd;

  //////////////////////////////////////////////////////////////////////
  // interrupt and dma routing, poll driver mode
  always_comb begin
    hostIrq = 8'h00;
    if (irqEnable && engIrq && cfg.irqLine >= ibc_pkg::IRQ_MIN) begin
      hostIrq[cfg.irqLine] = 1'b1;
    end
  end

  always_comb begin
    hostDrq = 4'h0;
    if (dmaEnable && engDmaReq && cfg.dmaChan != 2'h0) begin
      hostDrq[cfg.dmaChan] = 1'b1;
    end
  end

  assign engDmaAck = dmaCycle;
  assign tcSeen = dmaCycle & hostTc & ioRdy;
  assign drvOpenCollector = engPollActive;

  //////////////////////////////////////////////////////////////////////
  // apb slave
  assign pready = 1'b1;
  assign apbWrite = psel & penable & pwrite;
  assign apbRead = psel & !pwrite;
  assign pslverr = psel & penable & paddr != ibc_pkg::CFG_OFF
    & paddr != ibc_pkg::CTRL_OFF & paddr != ibc_pkg::STAT_OFF;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg.baseSel <= ibc_pkg::BASE_RST;
      cfg.dmaChan <= ibc_pkg::DMA_RST;
      cfg.irqLine <= ibc_pkg::IRQ_RST;
    end else if (apbWrite && paddr == ibc_pkg::CFG_OFF) begin
      cfg.baseSel <= pwdata[ibc_pkg::CFG_BASE_LSB +: 2];
      cfg.dmaChan <= pwdata[ibc_pkg::CFG_DMA_LSB +: 2];
      cfg.irqLine <= pwdata[ibc_pkg::CFG_IRQ_LSB +: 3];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqEnable <= 1'b0;
    end else if (apbWrite && paddr == ibc_pkg::CTRL_OFF) begin
      irqEnable <= pwdata[ibc_pkg::CTRL_IRQEN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dmaEnable <= 1'b0;
    end else if (tcSeen) begin
      dmaEnable <= 1'b0;
    end else if (apbWrite && paddr == ibc_pkg::CTRL_OFF) begin
      dmaEnable <= pwdata[ibc_pkg::CTRL_DMAEN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dmaDone <= 1'b0;
    end else if (tcSeen) begin
      dmaDone <= 1'b1;
    end else if (apbWrite && paddr == ibc_pkg::STAT_OFF
                 && pwdata[ibc_pkg::STAT_DONE_BIT]) begin
      dmaDone <= 1'b0;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (apbRead) begin
      case (paddr)
        ibc_pkg::CFG_OFF: prdata[6:0] = cfg;
        ibc_pkg::CTRL_OFF: begin
          prdata[ibc_pkg::CTRL_IRQEN_BIT] = irqEnable;
          prdata[ibc_pkg::CTRL_DMAEN_BIT] = dmaEnable;
        end
        ibc_pkg::STAT_OFF: begin
          prdata[ibc_pkg::STAT_DONE_BIT] = dmaDone;
          prdata[ibc_pkg::STAT_IRQ_BIT] = engIrq;
          prdata[ibc_pkg::STAT_EMPTY_BIT] = !fifoOutValid;
          prdata[ibc_pkg::STAT_FULL_BIT] = !fifoInReady;
          prdata[ibc_pkg::STAT_POLL_BIT] = engPollActive;
        end
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** dv/ibc_eng_model.sv ***
// behavioural model of the bus protocol engine
module ibc_eng_model (
  input wire logic mclk,
  input wire logic engCs,
  input wire logic engRd,
  input wire logic engWr,
  input wire logic [2:0] engAddr,
  input wire logic [7:0] engDout,
  input wire logic [3:0] delay,
  output logic [7:0] engDin,
  output logic engRdy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [8];
  logic [7:0] last = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial engRdy = 1'b0;
  // delay 4'hf stalls until changed
  always @(posedge mclk) begin
    engRdy <= 1'b0;
    cnt <= 4'h0;
    if (engCs && (engRd || engWr) && !engRdy) begin
      cnt <= cnt + 4'h1;
      if (cnt >= delay && delay != 4'hf) begin
        engRdy <= 1'b1;
        if (engWr) regs[engAddr] <= engDout;
      end
    end
    if (engRd) last <= regs[engAddr];
  end
  // bus not driven by the engine shows the inverse of its last value
  assign engDin = engRd ? regs[engAddr] : ~last;
endmodule

// *** dv/ibc_glue_chk.sv ***
// port checker for the instrument bus card glue
module ibc_glue_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioRd,
  input wire logic ioWr,
  input wire logic ioRdy,
  input wire logic ioDoe,
  input wire logic [7:0] hostIrq,
  input wire logic [3:0] hostDrq,
  input wire logic [3:0] hostDack,
  input wire logic engRd,
  input wire logic engWr,
  input wire logic engRdy,
  input wire logic engIrq,
  input wire logic engPollActive,
  input wire logic clkCs,
  input wire logic drvOpenCollector
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic miss;
  assign miss = ioAddr[9:0] != 10'h2e1 && ioAddr[15:3] != 13'h005e;
  sequence rd_end_s;
    engRd && engRdy;
  endsequence
  sequence ack_s;
    ioRdy && ioDoe;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  miss_quiet_a:
    assert property ((ioRd || ioWr) && miss && hostDack == 4'h0 |-> !ioRdy)
    else $error("ack on unmatched address");
  rd_ack_a:
    assert property (rd_end_s |=> ack_s) else $error("read not acked");
  wr_hold_a:
    assert property (engWr && !engRdy |=> engWr) else $error("write dropped");
  irq_gate_a:
    assert property (hostIrq != 8'h00 |-> engIrq) else $error("stray irq");
  irq_line_a:
    assert property ($onehot0(hostIrq) && hostIrq[1:0] == 2'h0)
    else $error("bad irq line");
  drq_line_a:
    assert property ($onehot0(hostDrq) && !hostDrq[0]) else $error("bad drq");
  poll_mode_a:
    assert property (drvOpenCollector == engPollActive)
    else $error("driver mode wrong");
  clk_space_a:
    assert property (clkCs |-> ioAddr[15] && ioAddr[9:0] == 10'h2e1)
    else $error("bad clock select");
endmodule
bind ibc_glue ibc_glue_chk chk (.mclk, .sys_rst, .ioAddr, .ioRd, .ioWr,
  .ioRdy, .ioDoe, .hostIrq, .hostDrq, .hostDack, .engRd, .engWr, .engRdy,
  .engIrq, .engPollActive, .clkCs, .drvOpenCollector);

// *** dv/tb_top.sv ***
// self-checking bench for the instrument bus card glue
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ioRd = 1'b0, ioWr = 1'b0, hostTc = 1'b0;
  logic engIrq = 1'b0, engDmaReq = 1'b0, engPollActive = 1'b0;
  logic [7:0] paddr = 8'h00, ioDin = 8'h00, ioDout, hostIrq, engDout;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic [15:0] ioAddr = 16'h0, lfsr = 16'h0015;
  logic [3:0] hostDack = 4'h0, dly = 4'h0, hostDrq;
  logic [7:0] engDin, rdByte, want [8];
  logic [2:0] engAddr;
  logic pready, pslverr, ioDoe, ioRdy, engCs, engRd, engWr, engDoe;
  logic engRdy, clkCs, drvOpenCollector, rdErr, csSeen, got, doe, engDmaAck;
  int mismatches = 0, checks = 0;
  always #10 mclk = ~mclk;
  ibc_glue dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ioAddr, .ioRd, .ioWr, .ioDin, .ioDout,
    .ioDoe, .ioRdy, .hostIrq, .hostDrq, .hostDack, .hostTc, .engCs, .engRd,
    .engWr, .engAddr, .engDout, .engDoe, .engDin, .engRdy, .engIrq,
    .engDmaReq, .engDmaAck, .engPollActive, .clkCs, .drvOpenCollector);
  ibc_eng_model eng (.mclk, .engCs, .engRd, .engWr, .engAddr, .engDout,
    .delay(dly), .engDin, .engRdy);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] hit(input int bs, rs, input logic cs);
    return {cs, 2'(bs), 3'(rs), 10'h2e1};
  endfunction
  function automatic logic [7:0] oneHot(input int n, input logic on);
    return on ? 8'h01 << n : 8'h00;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, w);
    checks++;
    if (g !== w) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic fail();
    mismatches++;
    $display("BAD %0t wait ran out", $time);
    end_of_test();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n <= 50; n++) begin
      if (n == 50) fail();
      @(posedge mclk);
      if (pready === 1'b1) begin
        rdData = prdata;
        rdErr = pslverr;
        break;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic io(input logic w, input logic [15:0] a,
      input logic [7:0] d, input int lim, input logic must);
    ioAddr <= a;
    ioDin <= d;
    ioWr <= w;
    ioRd <= !w;
    got = 1'b0;
    for (int n = 0; n < lim && !got; n++) begin
      @(posedge mclk);
      got = ioRdy === 1'b1;
      rdByte = ioDout;
      doe = ioDoe;
      csSeen = clkCs;
    end
    ioWr <= 1'b0;
    ioRd <= 1'b0;
    @(posedge mclk);
    if (must && !got) fail();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, 8'h00, 0);
    chk(rdData, 32'h4);
    apb(1'b0, 8'h0c, 0);
    chk({rdErr, rdData[7:0]}, 9'h100);
    io(1'b1, 16'h02e1, 8'h5a, 20, 1'b1);
    io(1'b0, 16'h02e1, 8'h00, 50, 1'b1);
    chk(rdByte, 8'h5a);
    for (int bs = 0; bs < 4; bs++) begin
      apb(1'b1, 8'h00, 32'h4 | bs);
      lfsr = nextRand(lfsr);
      dly <= lfsr[3:0] & 4'h7;
      for (int k = 0; k < 8; k++) begin
        lfsr = nextRand(lfsr);
        want[k] = lfsr[7:0];
        io(1'b1, hit(bs, k, 1'b0), want[k], 200, 1'b1);
      end
      for (int k = 0; k < 8; k++) begin
        io(1'b0, hit(bs, k, 1'b0), 8'h00, 400, 1'b1);
        chk(rdByte, want[k]);
      end
      io(1'b0, hit(bs + 1, 0, 1'b0), 8'h00, 6, 1'b0);
      chk({got, doe}, 2'b00);
      io(1'b0, hit(bs, 0, 1'b1), 8'h00, 20, 1'b1);
      chk({csSeen, rdByte}, 9'h1ff);
    end
    dly <= 4'hf;
    for (int k = 0; k < 9; k++) io(1'b1, hit(3, 7, 1'b0), 8'(k), 20, 1'b1);
    io(1'b1, hit(3, 7, 1'b0), 8'h99, 6, 1'b0);
    chk(got, 1'b0);
    apb(1'b0, 8'h08, 0);
    chk(rdData[3:2], 2'b10);
    dly <= 4'h0;
    io(1'b0, hit(3, 7, 1'b0), 8'h00, 400, 1'b1);
    chk(rdByte, 8'h08);
    apb(1'b0, 8'h08, 0);
    chk(rdData[3:2], 2'b01);
    engIrq <= 1'b1;
    for (int ln = 0; ln < 8; ln++) begin
      for (int en = 0; en < 2; en++) begin
        apb(1'b1, 8'h00, 32'h4 | (ln << 4));
        apb(1'b1, 8'h04, en);
        chk(hostIrq, oneHot(ln, en == 1 && ln >= 2));
      end
    end
    engPollActive <= 1'b1;
    io(1'b0, 16'h02f3, 8'h00, 20, 1'b1);
    chk(rdByte, 8'h13);
    chk(drvOpenCollector, 1'b1);
    engDmaReq <= 1'b1;
    hostDack <= 4'h8;
    for (int ch = 0; ch < 4; ch++) begin
      apb(1'b1, 8'h00, ch << 2);
      apb(1'b1, 8'h04, 32'h2);
      chk(hostDrq, 4'(oneHot(ch, ch != 0)));
      chk(engDmaAck, ch == 3);
    end
    hostTc <= 1'b1;
    io(1'b1, 16'h0000, 8'h77, 20, 1'b1);
    hostDack <= 4'h0;
    hostTc <= 1'b0;
    apb(1'b0, 8'h08, 0);
    chk(rdData[0], 1'b1);
    chk(hostDrq, 4'h0);
    end_of_test();
  end
endmodule
